// >>> rtl/fvx_pkg.sv
/*
 constants, types and state codes for the flash verify and exit link.
 assumes one 20 MHz system clock and a 4-wire test port sampled by it.
*/
package fvx_pkg;
   localparam int unsigned CLOCK_HZ = 20_000_000;
   localparam int unsigned RC_NOMINAL_HZ = 8_000_000;
   localparam int IR_W = 5;
   localparam logic [4:0] IR_CAPTURE = 5'h01;
   localparam logic [4:0] IR_DEFAULT = 5'h01;
   localparam logic [4:0] IR_CONTROL = 5'h0A;
   localparam logic [4:0] IR_DATA = 5'h09;
   localparam logic [4:0] IR_FAST = 5'h0E;
   localparam int ACC_BIT = 18;
   localparam logic [15:0] CMD_GET_CRC = 16'h0008;
   localparam logic [15:0] REPLY_PASS = 16'h0000;
   localparam logic [15:0] REPLY_FAIL = 16'h0002;
   localparam logic [15:0] REPLY_UNKNOWN = 16'h0003;
   localparam logic [31:0] FAST_WINDOW_ADDR = 32'hFF200000;
   localparam logic [15:0] OP_LUI_BASE = 16'h3C13;
   localparam logic [15:0] OP_LUI_ADDR = 16'h3C08;
   localparam logic [15:0] OP_ORI_ADDR = 16'h3508;
   localparam logic [31:0] INS_LOAD_WORD = 32'h8D090000;
   localparam logic [31:0] INS_STORE_WORD = 32'hAE690000;
   localparam logic [31:0] WORD_STEP = 32'h00000004;
   localparam logic [31:0] ONE_WORD = 32'h00000001;
   localparam logic [1:0] RESP_HEAD_ONLY = 2'h1;
   localparam logic [1:0] RESP_HEAD_SUM = 2'h2;
   localparam int PIN_TCK = 0;
   localparam int PIN_TMS = 1;
   localparam int PIN_TDI = 2;
   localparam int PIN_MASTER_CLEAR_PIN = 3;

   typedef enum logic [3:0] {
      TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
      TS_PA_DR, TS_EX2_DR, TS_UP_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR,
      TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UP_IR
   } fvx_tap_t;

   typedef enum logic [1:0] {
      UPD_NONE, UPD_CTRL, UPD_DATA, UPD_FAST
   } fvx_upd_t;

   typedef enum logic [2:0] {
      XW_CMD, XW_ADDR, XW_LEN, XW_RUN, XW_ZERO, XW_REPLY
   } fvx_exec_t;
endpackage

// >>> rtl/fvx_sum_engine.sv
/*
 flash word summing engine: reads a run of words and adds them up.
 assumes flash data is valid the cycle after the read strobe.
*/
module fvx_sum_engine
   import fvx_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [31:0] baseAddr,
   input wire logic [31:0] wordCount,
   input wire logic [31:0] flashData,
   output logic [31:0] flashAddr,
   output logic flashRead,
   output logic busy,
   output logic done,
   output logic [31:0] sum
);
   logic [31:0] addr, next_addr, left, next_left, next_sum, next_flashAddr;
   logic dataDue, next_dataDue, next_flashRead, next_busy, next_done;

   always_comb begin
      next_addr = addr;
      next_left = left;
      next_sum = sum;
      next_flashAddr = flashAddr;
      next_flashRead = 1'b0;
      next_dataDue = flashRead;
      next_busy = busy;
      next_done = 1'b0;
      if (start) begin
         next_busy = 1'b1;
         next_addr = baseAddr;
         next_left = wordCount;
         next_sum = 32'h00000000;
         next_dataDue = 1'b0;
      end else if (busy) begin
         if (dataDue) begin
            next_sum = sum + flashData;
         end
         if (left != 32'h00000000) begin
            next_flashRead = 1'b1;
            next_flashAddr = addr;
            next_addr = addr + WORD_STEP;
            next_left = left - ONE_WORD;
         end else if (!flashRead && !dataDue) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         addr <= 32'h00000000;
         left <= 32'h00000000;
         sum <= 32'h00000000;
         flashAddr <= 32'h00000000;
         flashRead <= 1'b0;
         dataDue <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         addr <= next_addr;
         left <= next_left;
         sum <= next_sum;
         flashAddr <= next_flashAddr;
         flashRead <= next_flashRead;
         dataDue <= next_dataDue;
         busy <= next_busy;
         done <= next_done;
      end
   end
endmodule

// >>> rtl/fvx_link.sv
/*
 device end of the test port: tap, control/data/fast-data registers,
 executive command handling and programming mode exit.
 assumes test pins and master clear are asynchronous to clock.
*/
module fvx_link
   import fvx_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic progClockPin,
   input wire logic modeSelectPin,
   input wire logic progDataPin,
   input wire logic masterClearPin,
   input wire logic executiveRun,
   input wire logic codeProtect,
   input wire logic [31:0] flashData,
   output logic testDataOut,
   output logic [31:0] flashAddr,
   output logic flashRead,
   output logic programmingMode,
   output logic userRun
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [3:0] syncA, syncB;
   logic tckPrev, tckRise, tckFall, tms, tdi, master_clear_pin;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         syncA <= 4'h0;
         syncB <= 4'h0;
         tckPrev <= 1'b0;
      end else begin
         syncA <= {masterClearPin, progDataPin, modeSelectPin, progClockPin};
         syncB <= syncA;
         tckPrev <= syncB[PIN_TCK];
      end
   end
   assign tckRise = syncB[PIN_TCK] && !tckPrev;
   assign tckFall = !syncB[PIN_TCK] && tckPrev;
   assign tms = syncB[PIN_TMS];
   assign tdi = syncB[PIN_TDI];
   assign master_clear_pin = syncB[PIN_MASTER_CLEAR_PIN];

   ////////////////////////////////////////////////////////////////////////
   // tap controller
   fvx_tap_t tap, next_tap;
   fvx_upd_t updKind, next_updKind;
   logic [4:0] ir, next_ir, irShift, next_irShift;
   logic [31:0] drShift, next_drShift, updWord, next_updWord, capVal;
   logic next_tdo;
   logic processorAccessFlag;
   logic [31:0] dataReg, fastTransferWindow;

   always_comb begin
      capVal = 32'h00000000;
      if (ir == IR_CONTROL) begin
         capVal[ACC_BIT] = processorAccessFlag;
      end else if (ir == IR_DATA) begin
         capVal = dataReg;
      end else if (ir == IR_FAST) begin
         capVal = fastTransferWindow;
      end
   end

   always_comb begin
      next_tap = tap;
      next_ir = ir;
      next_irShift = irShift;
      next_drShift = drShift;
      next_updWord = updWord;
      next_updKind = UPD_NONE;
      next_tdo = testDataOut;
      if (tckRise) begin
         case (tap)
            TS_RESET: next_ir = IR_DEFAULT;
            TS_CAP_DR: next_drShift = capVal;
            TS_SH_DR: next_drShift = {tdi, drShift[31:1]};
            TS_CAP_IR: next_irShift = IR_CAPTURE;
            TS_SH_IR: next_irShift = {tdi, irShift[4:1]};
            TS_UP_IR: next_ir = irShift;
            TS_UP_DR: begin
               next_updWord = drShift;
               if (ir == IR_CONTROL) begin
                  next_updKind = UPD_CTRL;
               end else if (ir == IR_DATA) begin
                  next_updKind = UPD_DATA;
               end else if (ir == IR_FAST) begin
                  next_updKind = UPD_FAST;
               end
            end
            default: next_tap = tap;
         endcase
         case (tap)
            TS_RESET: next_tap = tms ? TS_RESET : TS_IDLE;
            TS_IDLE: next_tap = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: next_tap = tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: next_tap = tms ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR: next_tap = tms ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: next_tap = tms ? TS_UP_DR : TS_PA_DR;
            TS_PA_DR: next_tap = tms ? TS_EX2_DR : TS_PA_DR;
            TS_EX2_DR: next_tap = tms ? TS_UP_DR : TS_SH_DR;
            TS_UP_DR: next_tap = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: next_tap = tms ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: next_tap = tms ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR: next_tap = tms ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: next_tap = tms ? TS_UP_IR : TS_PA_IR;
            TS_PA_IR: next_tap = tms ? TS_EX2_IR : TS_PA_IR;
            TS_EX2_IR: next_tap = tms ? TS_UP_IR : TS_SH_IR;
            default: next_tap = tms ? TS_SEL_DR : TS_IDLE;
         endcase
      end
      if (tckFall) begin
         next_tdo = (tap == TS_SH_DR) ? drShift[0] :
                    (tap == TS_SH_IR) ? irShift[0] : 1'b0;
      end
      if (!programmingMode) begin
         next_tap = TS_RESET;
         next_ir = IR_DEFAULT;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tap <= TS_RESET;
         ir <= IR_DEFAULT;
         irShift <= 5'h00;
         drShift <= 32'h00000000;
         updWord <= 32'h00000000;
         updKind <= UPD_NONE;
         testDataOut <= 1'b0;
      end else begin
         tap <= next_tap;
         ir <= next_ir;
         irShift <= next_irShift;
         drShift <= next_drShift;
         updWord <= next_updWord;
         updKind <= next_updKind;
         testDataOut <= next_tdo;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // processor access, executive and direct instruction path
   fvx_exec_t xState, next_xState;
   logic [31:0] next_dataReg, next_fast, baseReg, next_baseReg;
   logic [31:0] addrReg, next_addrReg, wordReg, next_wordReg;
   logic [31:0] returnedChecksum, next_checksum, engBase, next_engBase;
   logic [31:0] engCount, next_engCount, engSum;
   logic [1:0] respLeft, next_respLeft;
   logic next_acc, engStart, next_engStart, engBusy, engDone;
   logic lwWait, next_lwWait, readLocked, next_locked, resetDone;
   logic next_progMode, next_userRun, clearNow, setTerm, fastUpd;
   logic [31:0] readWord;

   assign clearNow = (updKind == UPD_CTRL) && !updWord[ACC_BIT]
                     && processorAccessFlag;
   assign fastUpd = (updKind == UPD_FAST);
   assign readWord = readLocked ? 32'h00000000 : engSum;

   always_comb begin
      next_dataReg = dataReg;
      next_fast = fastTransferWindow;
      next_baseReg = baseReg;
      next_addrReg = addrReg;
      next_wordReg = wordReg;
      next_checksum = returnedChecksum;
      next_engBase = engBase;
      next_engCount = engCount;
      next_engStart = 1'b0;
      next_respLeft = respLeft;
      next_xState = xState;
      next_lwWait = lwWait;
      next_locked = resetDone ? readLocked : codeProtect;
      if (updKind == UPD_DATA) begin
         next_dataReg = updWord;
      end
      if (executiveRun) begin
         case (xState)
            XW_CMD: if (fastUpd) begin
               if (updWord[31:16] == CMD_GET_CRC) begin
                  next_xState = XW_ADDR;
               end else begin
                  next_dataReg = {updWord[31:16], REPLY_UNKNOWN};
                  next_respLeft = RESP_HEAD_ONLY;
                  next_xState = XW_REPLY;
               end
            end
            XW_ADDR: if (fastUpd) begin
               next_engBase = updWord;
               next_xState = XW_LEN;
            end
            XW_LEN: if (fastUpd) begin
               next_engCount = updWord;
               next_engStart = 1'b1;
               next_xState = XW_RUN;
            end
            XW_RUN: if (engDone) begin
               next_fast = readWord;
               next_checksum = readWord;
               next_xState = XW_ZERO;
            end
            XW_ZERO: if (fastUpd) begin
               next_dataReg = {CMD_GET_CRC,
                               readLocked ? REPLY_FAIL : REPLY_PASS};
               next_respLeft = RESP_HEAD_SUM;
               next_xState = XW_REPLY;
            end
            default: if (clearNow) begin
               next_respLeft = respLeft - RESP_HEAD_ONLY;
               next_dataReg = returnedChecksum;
               if (respLeft == RESP_HEAD_ONLY) begin
                  next_xState = XW_CMD;
               end
            end
         endcase
      end else begin
         next_xState = XW_CMD;
         next_respLeft = 2'h0;
         if (fastUpd) begin
            next_fast = updWord;
         end
         if (clearNow) begin
            if (dataReg[31:16] == OP_LUI_BASE) begin
               next_baseReg = {dataReg[15:0], 16'h0000};
            end else if (dataReg[31:16] == OP_LUI_ADDR) begin
               next_addrReg = {dataReg[15:0], 16'h0000};
            end else if (dataReg[31:16] == OP_ORI_ADDR) begin
               next_addrReg = addrReg | {16'h0000, dataReg[15:0]};
            end else if (dataReg == INS_LOAD_WORD) begin
               next_engBase = addrReg;
               next_engCount = ONE_WORD;
               next_engStart = 1'b1;
               next_lwWait = 1'b1;
            end else if (dataReg == INS_STORE_WORD
                         && baseReg == FAST_WINDOW_ADDR) begin
               next_fast = wordReg;
            end
         end
         if (lwWait && engDone) begin
            next_wordReg = readWord;
            next_lwWait = 1'b0;
         end
      end
      setTerm = executiveRun ? (respLeft != 2'h0)
                             : (!lwWait && !engStart);
      next_acc = (clearNow ? 1'b0 : processorAccessFlag)
                 | (setTerm && !clearNow);
      next_progMode = master_clear_pin;
      next_userRun = master_clear_pin ? 1'b0 : (userRun | programmingMode);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dataReg <= 32'h00000000;
         fastTransferWindow <= 32'h00000000;
         baseReg <= 32'h00000000;
         addrReg <= 32'h00000000;
         wordReg <= 32'h00000000;
         returnedChecksum <= 32'h00000000;
         engBase <= 32'h00000000;
         engCount <= 32'h00000000;
         engStart <= 1'b0;
         respLeft <= 2'h0;
         xState <= XW_CMD;
         lwWait <= 1'b0;
         readLocked <= 1'b0;
         resetDone <= 1'b0;
         processorAccessFlag <= 1'b0;
         programmingMode <= 1'b0;
         userRun <= 1'b0;
      end else begin
         dataReg <= next_dataReg;
         fastTransferWindow <= next_fast;
         baseReg <= next_baseReg;
         addrReg <= next_addrReg;
         wordReg <= next_wordReg;
         returnedChecksum <= next_checksum;
         engBase <= next_engBase;
         engCount <= next_engCount;
         engStart <= next_engStart;
         respLeft <= next_respLeft;
         xState <= next_xState;
         lwWait <= next_lwWait;
         readLocked <= next_locked;
         resetDone <= 1'b1;
         processorAccessFlag <= next_acc;
         programmingMode <= next_progMode;
         userRun <= next_userRun;
      end
   end

   fvx_sum_engine engine (
      .clock(clock),
      .rst_n(rst_n),
      .start(engStart),
      .baseAddr(engBase),
      .wordCount(engCount),
      .flashData(flashData),
      .flashAddr(flashAddr),
      .flashRead(flashRead),
      .busy(engBusy),
      .done(engDone),
      .sum(engSum)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_CRC_CODE: assert property (@(posedge clock) disable iff (!rst_n)
      executiveRun && xState == XW_CMD && fastUpd
      && updWord[31:16] == CMD_GET_CRC |=> xState == XW_ADDR)
      else $error("crc query not accepted");
   AST_UNKNOWN_REPLY: assert property (@(posedge clock)
      disable iff (!rst_n)
      executiveRun && xState == XW_CMD && fastUpd
      && updWord[31:16] != CMD_GET_CRC
      |=> dataReg[15:0] == REPLY_UNKNOWN && respLeft == RESP_HEAD_ONLY
      ##1 processorAccessFlag)
      else $error("unknown command reply wrong");
   AST_ONE_OUTSTANDING: assert property (@(posedge clock)
      disable iff (!rst_n || !executiveRun)
      xState == XW_REPLY && fastUpd |=> xState == XW_REPLY
      && $stable(respLeft))
      else $error("command taken while reply open");
   AST_SECOND_WORD: assert property (@(posedge clock)
      disable iff (!rst_n || !executiveRun)
      xState == XW_REPLY && clearNow && respLeft == RESP_HEAD_SUM
      |=> dataReg == returnedChecksum && respLeft == RESP_HEAD_ONLY)
      else $error("second reply word missing");
   AST_CHECKSUM_WINDOW: assert property (@(posedge clock)
      disable iff (!rst_n || !executiveRun)
      xState == XW_RUN && engDone && !readLocked
      |=> fastTransferWindow == $past(engSum) && xState == XW_ZERO)
      else $error("checksum not placed in fast window");
   AST_LOCKED_READ: assert property (@(posedge clock)
      disable iff (!rst_n || !executiveRun)
      xState == XW_RUN && engDone && readLocked
      |=> fastTransferWindow == 32'h00000000 ##1 !fastUpd [*1]
      ##0 readLocked)
      else $error("protected flash was read");
   AST_STORE_WINDOW: assert property (@(posedge clock)
      disable iff (!rst_n || executiveRun)
      clearNow && dataReg == INS_STORE_WORD && baseReg == FAST_WINDOW_ADDR
      |=> fastTransferWindow == $past(wordReg))
      else $error("store to fast window lost");
   AST_EXIT: assert property (@(posedge clock) disable iff (!rst_n)
      programmingMode && !master_clear_pin |=> !programmingMode && userRun
      ##1 tap == TS_RESET)
      else $error("programming mode not left");
   AST_HOST_FIRST: assert property (@(posedge clock)
      disable iff (!rst_n || !executiveRun)
      processorAccessFlag && !clearNow |-> respLeft != 2'h0)
      else $error("reply without command");
   COV_UNKNOWN: cover property (@(posedge clock) disable iff (!rst_n)
      xState == XW_CMD ##1 xState == XW_REPLY);
   COV_CRC_DONE: cover property (@(posedge clock) disable iff (!rst_n)
      xState == XW_RUN ##1 xState == XW_ZERO);
   COV_DIRECT_STORE: cover property (@(posedge clock) disable iff (!rst_n)
      !executiveRun && clearNow && dataReg == INS_STORE_WORD);
endmodule

// >>> testbench/fvx_host_model.sv
/*
 programmer tool model: drives the 4-wire test port bit by bit.
 assumes pins are sampled by the device clock; tasks are run from tb.
*/
module fvx_host_model
   import fvx_pkg::*;
#(
   parameter int HOLD_CYCLES = 20
)
(
   input wire logic clock,
   input wire logic testDataOut,
   output logic progClockPin,
   output logic modeSelectPin,
   output logic progDataPin,
   output logic masterClearPin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      progClockPin = 1'b0;
      modeSelectPin = 1'b1;
      progDataPin = 1'b0;
      masterClearPin = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // one 400 ns test clock period, tdo taken at the rise
   task automatic pulse(input logic tms, input logic tdi, output logic tdo);
      @(posedge clock);
      progClockPin <= 1'b0;
      modeSelectPin <= tms;
      progDataPin <= tdi;
      repeat (4) @(posedge clock);
      tdo = testDataOut;
      progClockPin <= 1'b1;
      repeat (3) @(posedge clock);
   endtask

   // ir or dr scan from idle back to idle, lsb first
   task automatic scan(input logic isIr, input logic [31:0] din,
                       output logic [31:0] dout);
      int n;
      logic t;
      n = isIr ? IR_W : 32;
      dout = '0;
      pulse(1'b1, 1'b0, t);
      if (isIr) pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, din[i], t);
         dout[i] = t;
      end
      pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      progDataPin <= ~din[n - 1];
   endtask

   task automatic toIdle();
      logic t;
      repeat (5) pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
   endtask

   // command words and data only as fast-data transfers
   task automatic fast(input logic [31:0] d, output logic [31:0] r);
      logic [31:0] v;
      scan(1'b1, {27'h0, IR_FAST}, v);
      scan(1'b0, d, r);
   endtask

   // poll access flag, exchange data word, release the cpu
   task automatic xact(input logic [31:0] d, output logic [31:0] r,
                       output logic ok);
      logic [31:0] v;
      ok = 1'b0;
      scan(1'b1, {27'h0, IR_CONTROL}, v);
      for (int k = 0; k < 50 && !ok; k++) begin
         scan(1'b0, 32'h0004C000, v);
         ok = v[ACC_BIT];
      end
      scan(1'b1, {27'h0, IR_DATA}, v);
      scan(1'b0, d, r);
      scan(1'b1, {27'h0, IR_CONTROL}, v);
      scan(1'b0, 32'h0000C000, v);
   endtask

   // five ones, hold interval, master clear low, 2-wire extra clock
   task automatic leave(input logic twoWire);
      logic t;
      repeat (5) pulse(1'b1, 1'b0, t);
      repeat (HOLD_CYCLES) @(posedge clock);
      masterClearPin <= 1'b0;
      if (twoWire) begin
         pulse(1'b1, 1'b0, t);
      end
   endtask

   // back to the programming-entry level
   task automatic enter();
      masterClearPin <= 1'b1;
   endtask
endmodule

// >>> testbench/tb.sv
/*
 self-checking bench for the link: crc query, direct readback, exit, lock.
 assumes fvx_host_model drives the test port; tb models the flash.
*/
module tb
   import fvx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock, rst_n, progClockPin, modeSelectPin, progDataPin;
   logic masterClearPin, executiveRun, codeProtect, testDataOut;
   logic [31:0] flashData, flashAddr, salt;
   logic flashRead, programmingMode, userRun;
   int badCount = 0;
   int numChecks = 0;
   int cycles = 0;

   fvx_link fvx_link_inst (.clock(clock), .rst_n(rst_n),
      .progClockPin(progClockPin), .modeSelectPin(modeSelectPin),
      .progDataPin(progDataPin), .masterClearPin(masterClearPin),
      .executiveRun(executiveRun), .codeProtect(codeProtect),
      .flashData(flashData), .testDataOut(testDataOut),
      .flashAddr(flashAddr), .flashRead(flashRead),
      .programmingMode(programmingMode), .userRun(userRun));

   fvx_host_model host (.clock(clock), .testDataOut(testDataOut),
      .progClockPin(progClockPin), .modeSelectPin(modeSelectPin),
      .progDataPin(progDataPin), .masterClearPin(masterClearPin));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] word(input logic [31:0] a);
      return (a * 32'h9E3779B1) ^ salt;
   endfunction

   function automatic logic [31:0] sumOf(input logic [31:0] a,
                                         input logic [31:0] n);
      logic [31:0] s;
      s = '0;
      for (int i = 0; i < n; i++) s += word(a + 32'(4 * i));
      return s;
   endfunction

   // flash answers a cycle after the strobe, garbage otherwise
   always @(posedge clock) begin
      flashData <= flashRead ? word(flashAddr) : ~word(flashAddr);
   end

   task automatic wrapUp();
      if (badCount == 0 && numChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      // about 40000 cycles expected, margin for slow polls
      if (cycles == 60000) begin
         badCount++;
         wrapUp();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("Error at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic doReset(input logic lock);
      @(posedge clock);
      rst_n <= 1'b0;
      codeProtect <= lock;
      executiveRun <= 1'b1;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (10) @(posedge clock);
      host.toIdle();
   endtask

   task automatic crcRun(input logic [31:0] a, input logic [31:0] n,
                         input logic lock);
      logic [31:0] r, exp;
      logic ok;
      exp = lock ? 32'h0 : sumOf(a, n);
      host.fast({CMD_GET_CRC, 16'h0000}, r);
      host.fast(a, r);
      host.fast(n, r);
      repeat (n + 10) @(posedge clock);
      host.fast(32'h0, r);
      chk(r, exp);
      host.xact(32'h0, r, ok);
      chk({31'h0, ok}, 32'h1);
      chk(r, {CMD_GET_CRC, lock ? REPLY_FAIL : REPLY_PASS});
      host.xact(32'h0, r, ok);
      chk(r, exp);
   endtask

   task automatic directRead(input logic [31:0] a);
      logic [31:0] r;
      logic ok;
      host.xact({OP_LUI_ADDR, a[31:16]}, r, ok);
      host.xact({OP_ORI_ADDR, a[15:0]}, r, ok);
      host.xact(INS_LOAD_WORD, r, ok);
      host.xact(INS_STORE_WORD, r, ok);
      chk({31'h0, ok}, 32'h1);
      host.fast(32'h0, r);
      chk(r, word(a));
   endtask

   initial begin
      logic [31:0] r;
      logic [15:0] op;
      logic ok;
      rst_n = 1'b0;
      executiveRun = 1'b1;
      codeProtect = 1'b0;
      void'($urandom(32'hAB30B245));
      salt = $urandom;
      doReset(1'b0);
      crcRun(32'h1D000000, 32'h1, 1'b0);
      for (int i = 0; i < 3; i++) begin
         crcRun($urandom & 32'h1FFFFFFC, $urandom_range(2, 12), 1'b0);
      end
      op = 16'h0010 + 16'($urandom_range(0, 200));
      host.fast({op, 16'h0000}, r);
      host.fast($urandom, r);
      host.xact(32'h0, r, ok);
      chk(r, {op, REPLY_UNKNOWN});
      repeat (4) @(posedge clock);
      executiveRun <= 1'b0;
      host.xact({OP_LUI_BASE, 16'hFF20}, r, ok);
      for (int i = 0; i < 3; i++) begin
         directRead($urandom & 32'h1FFFFFFC);
      end
      host.leave(1'b0);
      repeat (10) @(posedge clock);
      chk({31'h0, programmingMode}, 32'h0);
      chk({31'h0, userRun}, 32'h1);
      host.enter();
      repeat (10) @(posedge clock);
      chk({31'h0, userRun}, 32'h0);
      chk({31'h0, programmingMode}, 32'h1);
      doReset(1'b1);
      crcRun($urandom & 32'h1FFFFFFC, 32'h4, 1'b1);
      host.leave(1'b1);
      repeat (10) @(posedge clock);
      chk({31'h0, programmingMode}, 32'h0);
      chk({31'h0, userRun}, 32'h1);
      wrapUp();
   end
endmodule
